/* src/hp_mix_pkg.sv */
package hp_mix_pkg;
    // Register offsets
    localparam logic [7:0] DAC_LEFT_TO_HP_LEFT_VOL = 8'h2f;
    localparam logic [7:0] LINE2_RIGHT_TO_HP_LEFT_VOL = 8'h30;
    localparam logic [7:0] GAIN_RIGHT_TO_HP_LEFT_VOL = 8'h31;
    localparam logic [7:0] DAC_RIGHT_TO_HP_LEFT_VOL = 8'h32;
    localparam logic [7:0] HP_LEFT_LEVEL_CTRL = 8'h33;
    localparam logic [7:0] LINE2_LEFT_TO_HP_COM_VOL = 8'h34;
    localparam logic [7:0] GAIN_LEFT_TO_HP_COM_VOL = 8'h35;
    localparam logic [7:0] DAC_LEFT_TO_HP_COM_VOL = 8'h36;
    localparam logic [7:0] LINE2_RIGHT_TO_HP_COM_VOL = 8'h37;
    localparam logic [7:0] GAIN_RIGHT_TO_HP_COM_VOL = 8'h38;
    // Path counts
    localparam int NUM_LEFT = 4;
    localparam int NUM_COM = 5;
    localparam int NUM_PATHS = 9;
    // Field positions
    localparam int ROUTE_BIT = 7;
    localparam int VOL_MSB = 6;
    localparam int VOL_W = 7;
    localparam int LEVEL_MSB = 7;
    localparam int LEVEL_LSB = 4;
    localparam int MUTE_BIT = 3;
    localparam int PD_DRIVE_BIT = 2;
    localparam int STATUS_BIT = 1;
    localparam int POWER_BIT = 0;
    // Reset values
    localparam logic ROUTE_RESET = 1'b0;
    localparam logic [6:0] VOL_RESET = 7'h00;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic UNMUTE_RESET = 1'b0;
    localparam logic PD_DRIVE_RESET = 1'b1;
    localparam logic PENDING_RESET = 1'b1;
    localparam logic POWER_RESET = 1'b0;
    // Volume codes at or above this mute the path
    localparam logic [6:0] VOL_MUTE_FIRST = 7'h76;
    // Gain ramp timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS = 100;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

    function automatic logic [7:0] path_offset(input int idx);
        logic [7:0] off;
        case (idx)
            0: off = DAC_LEFT_TO_HP_LEFT_VOL;
            1: off = LINE2_RIGHT_TO_HP_LEFT_VOL;
            2: off = GAIN_RIGHT_TO_HP_LEFT_VOL;
            3: off = DAC_RIGHT_TO_HP_LEFT_VOL;
            4: off = LINE2_LEFT_TO_HP_COM_VOL;
            5: off = GAIN_LEFT_TO_HP_COM_VOL;
            6: off = DAC_LEFT_TO_HP_COM_VOL;
            7: off = LINE2_RIGHT_TO_HP_COM_VOL;
            default: off = GAIN_RIGHT_TO_HP_COM_VOL;
        endcase
        return off;
    endfunction : path_offset
endpackage : hp_mix_pkg

/* src/path_gain_ctrl.sv */
module path_gain_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic step_i,
    output logic route_o,
    output logic [6:0] code_o,
    output logic [6:0] applied_o,
    output logic mute_o,
    output logic busy_o
);
    logic [6:0] next_applied;

    // Applied gain walks one code per step to avoid zipper noise
    always_comb begin
        next_applied = applied_o;
        if (step_i && applied_o < code_o) begin
            next_applied = applied_o + 7'h01;
        end else if (step_i && applied_o > code_o) begin
            next_applied = applied_o - 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            route_o <= hp_mix_pkg::ROUTE_RESET;
        end else if (wr_i) begin
            route_o <= wdata_i[hp_mix_pkg::ROUTE_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            code_o <= hp_mix_pkg::VOL_RESET;
        end else if (wr_i) begin
            code_o <= wdata_i[hp_mix_pkg::VOL_MSB:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            applied_o <= hp_mix_pkg::VOL_RESET;
        end else begin
            applied_o <= next_applied;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mute_o <= 1'b0;
        end else begin
            mute_o <= next_applied >= hp_mix_pkg::VOL_MUTE_FIRST;
        end
    end

    assign busy_o = applied_o != code_o;
endmodule : path_gain_ctrl

/* src/headphone_mixer_route_regs.sv */
// Summary of operation
// - Top bit of each left headphone path register connects that source.
// - Low seven bits of each left headphone path hold attenuation, reset zero.
// - Top bit of each common headphone path register connects that source.
// - Low seven bits of each common headphone path hold attenuation, reset zero.
// - Level field in upper nibble selects 0 to 9 dB, reset zero.
// - Mute bit zero mutes driver, one unmutes; starts muted.
// - Power-down drive bit: zero weak common-mode, one tri-state; reset one.
// - Status bit reads one while gains pending, zero once applied.
// - Bit zero powers driver fully up when set, reset zero.
// - Right gain stage to left headphone has its own independent register.
// - Code zero is 0 dB, half-dB steps down; 118 and above mute.
module headphone_mixer_route_regs (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [3:0] hp_left_route_o,
    output logic [27:0] hp_left_vol_o,
    output logic [3:0] hp_left_path_mute_o,
    output logic [4:0] hp_com_route_o,
    output logic [34:0] hp_com_vol_o,
    output logic [4:0] hp_com_path_mute_o,
    output logic [3:0] hp_left_level_o,
    output logic hp_left_unmute_o,
    output logic hp_left_pd_tristate_o,
    output logic hp_left_power_up_o
);
    logic [7:0] step_cnt;
    logic step;
    logic pending;
    logic level_wr;
    logic [8:0] path_wr;
    logic [8:0] route;
    logic [8:0] busy;
    logic [8:0] pmute;
    logic [6:0] code [9];
    logic [6:0] applied [9];
    logic [7:0] next_rdata;

    // Shared ramp tick
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            step_cnt <= 8'h00;
        end else if (step_cnt == hp_mix_pkg::STEP_LAST) begin
            step_cnt <= 8'h00;
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end
    assign step = step_cnt == hp_mix_pkg::STEP_LAST;

    assign level_wr = reg_wr_i && reg_addr_i == hp_mix_pkg::HP_LEFT_LEVEL_CTRL;

    generate
        for (genvar i = 0; i < hp_mix_pkg::NUM_PATHS; i++) begin : g_path
            assign path_wr[i] = reg_wr_i && reg_addr_i == hp_mix_pkg::path_offset(i);
            path_gain_ctrl u_path (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .wr_i(path_wr[i]),
                .wdata_i(reg_wdata_i),
                .step_i(step),
                .route_o(route[i]),
                .code_o(code[i]),
                .applied_o(applied[i]),
                .mute_o(pmute[i]),
                .busy_o(busy[i])
            );
            if (i < hp_mix_pkg::NUM_LEFT) begin : g_left
                assign hp_left_route_o[i] = route[i];
                assign hp_left_vol_o[7*i +: 7] = applied[i];
                assign hp_left_path_mute_o[i] = pmute[i];
            end else begin : g_com
                assign hp_com_route_o[i-4] = route[i];
                assign hp_com_vol_o[7*(i-4) +: 7] = applied[i];
                assign hp_com_path_mute_o[i-4] = pmute[i];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hp_left_level_o <= hp_mix_pkg::LEVEL_RESET;
        end else if (level_wr) begin
            hp_left_level_o <= reg_wdata_i[hp_mix_pkg::LEVEL_MSB:hp_mix_pkg::LEVEL_LSB];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hp_left_unmute_o <= hp_mix_pkg::UNMUTE_RESET;
            hp_left_pd_tristate_o <= hp_mix_pkg::PD_DRIVE_RESET;
            hp_left_power_up_o <= hp_mix_pkg::POWER_RESET;
        end else if (level_wr) begin
            hp_left_unmute_o <= reg_wdata_i[hp_mix_pkg::MUTE_BIT];
            hp_left_pd_tristate_o <= reg_wdata_i[hp_mix_pkg::PD_DRIVE_BIT];
            hp_left_power_up_o <= reg_wdata_i[hp_mix_pkg::POWER_BIT];
        end
    end

    // Write sets pending; a write wins over clearing
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pending <= hp_mix_pkg::PENDING_RESET;
        end else begin
            pending <= level_wr || (|path_wr) || (|busy);
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        for (int k = 0; k < hp_mix_pkg::NUM_PATHS; k++) begin
            if (reg_addr_i == hp_mix_pkg::path_offset(k)) begin
                next_rdata = {route[k], code[k]};
            end
        end
        if (reg_addr_i == hp_mix_pkg::HP_LEFT_LEVEL_CTRL) begin
            next_rdata = {hp_left_level_o, hp_left_unmute_o, hp_left_pd_tristate_o, pending, hp_left_power_up_o};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    route_follow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        path_wr[0] |=> hp_left_route_o[0] == $past(reg_wdata_i[7]))
        else $error("left route bit not taken");
    com_route_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        path_wr[8] |=> hp_com_route_o[4] == $past(reg_wdata_i[7]) && code[8] == $past(reg_wdata_i[6:0]))
        else $error("common path register not taken");
    vol_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !step |=> $stable(hp_left_vol_o[6:0]))
        else $error("applied volume moved off step");
    mute_map_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hp_left_path_mute_o[0] == (hp_left_vol_o[6:0] >= 7'h76))
        else $error("path mute not tied to code");
    code_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!path_wr[2] && !route[2]) |=> $stable(code[2]))
        else $error("volume lost while unrouted");
    path_indep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        path_wr[2] |=> $stable(code[1]) && $stable(route[3]))
        else $error("neighbour path disturbed");
    level_take_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        level_wr |=> hp_left_level_o == $past(reg_wdata_i[7:4]) && hp_left_unmute_o == $past(reg_wdata_i[3]))
        else $error("level register not taken");
    drive_take_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        level_wr |=> hp_left_pd_tristate_o == $past(reg_wdata_i[2]) && hp_left_power_up_o == $past(reg_wdata_i[0]))
        else $error("drive or power bit not taken");
    pending_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (|path_wr) |=> pending)
        else $error("pending not set by write");
    pending_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!(|busy) && !(|path_wr) && !level_wr) |=> !pending)
        else $error("pending stuck after apply");
endmodule : headphone_mixer_route_regs

/* sim/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [3:0] hp_left_route_o;
    logic [27:0] hp_left_vol_o;
    logic [3:0] hp_left_path_mute_o;
    logic [4:0] hp_com_route_o;
    logic [34:0] hp_com_vol_o;
    logic [4:0] hp_com_path_mute_o;
    logic [3:0] hp_left_level_o;
    logic hp_left_unmute_o;
    logic hp_left_pd_tristate_o;
    logic hp_left_power_up_o;
    int err_total = 0;
    int checks = 0;
    logic [7:0] rd_val;
    logic [6:0] c;
    logic [2:0] b;
    logic [6:0] codes [9];
    // Own offset table, kept apart from the design's lookup
    logic [7:0] offs [9] = '{8'h2f, 8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38};

    headphone_mixer_route_regs dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .hp_left_route_o(hp_left_route_o), .hp_left_vol_o(hp_left_vol_o),
        .hp_left_path_mute_o(hp_left_path_mute_o), .hp_com_route_o(hp_com_route_o), .hp_com_vol_o(hp_com_vol_o),
        .hp_com_path_mute_o(hp_com_path_mute_o), .hp_left_level_o(hp_left_level_o),
        .hp_left_unmute_o(hp_left_unmute_o), .hp_left_pd_tristate_o(hp_left_pd_tristate_o),
        .hp_left_power_up_o(hp_left_power_up_o));

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : tick

    // Idle cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
        tick(1);
    endtask : rd

    function automatic logic [8:0] path_state(input int i);
        if (i < 4) return {hp_left_path_mute_o[i], hp_left_route_o[i], hp_left_vol_o[7*i +: 7]};
        return {hp_com_path_mute_o[i-4], hp_com_route_o[i-4], hp_com_vol_o[7*(i-4) +: 7]};
    endfunction : path_state

    function automatic logic [8:0] exp_state(input logic r, input logic [6:0] code);
        return {code >= hp_mix_pkg::VOL_MUTE_FIRST, r, code};
    endfunction : exp_state

    // Ramp is one code per 4 cycles, so 600 cycles covers the full range
    task automatic settle(input int i, input logic [6:0] code);
        for (int n = 0; n < 600 && (path_state(i) & 9'h07f) !== {2'b00, code}; n++) tick(1);
    endtask : settle

    task automatic tally_and_finish();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(20000 * 25);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(37));
        tick(10);
        rst_n_i = 1'b1;
        tick(3);
        for (int i = 0; i < 9; i++) begin
            rd(offs[i], rd_val);
            cmp({1'b0, rd_val}, 9'h000);
            cmp(path_state(i), 9'h000);
        end
        rd(8'h33, rd_val);
        cmp({1'b0, rd_val}, 9'h004);
        rd(8'h2e, rd_val);
        cmp({1'b0, rd_val}, 9'h000);
        wr(8'h39, 8'hff);
        rd(8'h39, rd_val);
        cmp({1'b0, rd_val}, 9'h000);
        cmp({4'h0, hp_com_route_o}, 9'h000);
        for (int i = 0; i < 9; i++) begin
            c = (i == 0) ? 7'h76 : (i == 1) ? 7'h75 : (i == 2) ? 7'h7f : 7'($urandom_range(16, 127));
            codes[i] = c;
            wr(offs[i], {1'b1, c});
            rd(8'h33, rd_val);
            cmp({8'h00, rd_val[1]}, 9'h001);
            settle(i, c);
            cmp(path_state(i), exp_state(1'b1, c));
            rd(offs[i], rd_val);
            cmp({1'b0, rd_val}, {2'b01, c});
        end
        tick(2);
        rd(8'h33, rd_val);
        cmp({8'h00, rd_val[1]}, 9'h000);
        for (int i = 0; i < 9; i++) cmp(path_state(i), exp_state(1'b1, codes[i]));
        wr(offs[2], {1'b0, codes[2]});
        cmp(path_state(2), exp_state(1'b0, codes[2]));
        wr(offs[2], {1'b1, codes[2]});
        cmp(path_state(2), exp_state(1'b1, codes[2]));
        wr(offs[3], 8'h85);
        settle(3, 7'h05);
        cmp(path_state(3), exp_state(1'b1, 7'h05));
        // every legal level, status bit written high is ignored
        for (int lv = 0; lv < 10; lv++) begin
            b = 3'($urandom());
            wr(8'h33, {4'(lv), b[2], b[1], 1'b1, b[0]});
            cmp({2'b00, hp_left_level_o, hp_left_unmute_o, hp_left_pd_tristate_o, hp_left_power_up_o},
                {2'b00, 4'(lv), b});
            tick(2);
            rd(8'h33, rd_val);
            cmp({1'b0, rd_val}, {1'b0, 4'(lv), b[2], b[1], 1'b0, b[0]});
        end
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        rd(8'h33, rd_val);
        cmp({1'b0, rd_val}, 9'h006);
        cmp(path_state(0), 9'h000);
        tally_and_finish();
    end
endmodule : tb
